// [logic/mon_pkg.sv]
// constants for the monitor fault status bank
// assumes one 20 MHz clock and a plain register port with 8-bit addresses
package mon_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int SUP_W  = 16;
    localparam int CLK_W  = 3;
    localparam int DIG_W  = 4;
    localparam int COM_W  = 5;
    localparam int IRQ_W  = 4;

    // register offsets
    localparam logic [7:0] A_PRIMARY   = 8'h00;
    localparam logic [7:0] A_SECONDARY = 8'h01;
    localparam logic [7:0] A_SUPPLY    = 8'h02;
    localparam logic [7:0] A_CLOCK     = 8'h03;
    localparam logic [7:0] A_DIGITAL   = 8'h04;
    localparam logic [7:0] A_SUP_EN    = 8'h05;
    localparam logic [7:0] A_SUP_DIAG  = 8'h06;
    localparam logic [7:0] A_MISC_EN   = 8'h07;
    localparam logic [7:0] A_MISC_DIAG = 8'h08;
    localparam logic [7:0] A_IRQ_STAT  = 8'h09;
    localparam logic [7:0] A_IRQ_CLR   = 8'h0a;
    localparam logic [7:0] A_IRQ_EN    = 8'h0b;

    // field positions inside the misc enable register
    localparam int MISC_TIMEOUT = 3;
    localparam int MISC_SCLK    = 4;
    localparam int MISC_SECT    = 5;

    // reset values, and the write mask for the supply diagnostic enables
    localparam logic [15:0] SUP_EN_RST    = 16'hffff;
    localparam logic [7:0]  MISC_EN_RST   = 8'hff;
    localparam logic [15:0] SUP_DIAG_MASK = 16'he1ff;
    localparam logic [4:0]  COM_RST       = 5'h0f;
    localparam logic [15:0] SUP_RST       = 16'hffff;
    localparam logic [2:0]  CLK_RST       = 3'h7;
    localparam logic [3:0]  DIG_RST       = 4'hf;

    // cycles from a raw monitor detect to the flag showing it
    localparam int FLAG_LATENCY = 3;
endpackage

// [logic/flag_if.sv]
// bundle between the status top and one bank of low-active flags
// assumes all members are driven in the sys_clk domain
`timescale 1ns/10ps
interface flag_if #(parameter int N = 1) ();
    logic [N-1:0] detect;
    logic [N-1:0] enable;
    logic [N-1:0] clear;
    logic [N-1:0] recover;
    logic [N-1:0] flag_n;
    logic         hit;
    modport bank (input detect, enable, clear, recover,
                  output flag_n, hit);
    modport user (output detect, enable, clear, recover,
                  input flag_n, hit);
endinterface

// [logic/sync2.sv]
// two-stage synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level, not a word
`timescale 1ns/10ps
module sync2 #(
    parameter int N = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // levels
    input  wire logic [N-1:0] d,
    output logic      [N-1:0] q
);
    logic [N-1:0] meta_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// [logic/flag_bank.sv]
// bank of sticky low-active fault flags
// assumes detect is already in the sys_clk domain
`timescale 1ns/10ps
module flag_bank #(
    parameter int           N       = 1,
    parameter logic [N-1:0] RST_VAL = '1
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // flag bundle
    flag_if.bank      fb
);
    logic [N-1:0] set_vec;
    logic [N-1:0] flag_reg;

    assign set_vec   = fb.detect & fb.enable;
    assign fb.hit    = |set_vec;
    assign fb.flag_n = flag_reg;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            // a fault still present wins over a clear
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_reg[i] <= RST_VAL[i];
                end else if (set_vec[i]) begin
                    flag_reg[i] <= 1'b0;
                end else if (fb.clear[i] || fb.recover[i]) begin
                    flag_reg[i] <= 1'b1;
                end
            end
        end
    endgenerate

    // checks, shared by every bank
    property p_latched;
        @(posedge sys_clk) disable iff (!rst_n)
        ((fb.clear | fb.recover) == '0) |=>
            ((fb.flag_n & ~$past(fb.flag_n)) == '0);
    endproperty
    a_latched: assert property (p_latched) // RULE2
        else $error("flag rose without a host clear or recovery");

    property p_clear_one;
        @(posedge sys_clk) disable iff (!rst_n)
        ((fb.clear & ~(fb.detect & fb.enable)) != '0) |=>
            ((~fb.flag_n & $past(fb.clear & ~(fb.detect & fb.enable)))
             == '0);
    endproperty
    a_clear_one: assert property (p_clear_one) // RULE3
        else $error("write of one did not return a flag to one");

    property p_disabled_quiet;
        @(posedge sys_clk) disable iff (!rst_n)
        ((fb.flag_n & ~fb.enable) != '0) |=>
            ((~fb.flag_n & $past(fb.flag_n & ~fb.enable)) == '0);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // RULE5
        else $error("disabled monitor pulled its flag low");
endmodule

// [logic/mon_status.sv]
// monitor fault status bank: latched fault flags, indicators, counters
// assumes monitor detects are async levels, serial events are sys_clk
// pulses, and the host uses the plain register port
//
// Summary of operation
// RULE1 - an enabled monitor fault drives its low-active flag to zero
// RULE2 - non-serial flags stay zero until host clears after fault ends
// RULE3 - writing one to a latched flag bit returns it to one
// RULE4 - serial fault flags recover in the frame after a clean frame
// RULE5 - enabled monitors report only when enabled; others always report
// RULE6 - diagnostic enables start a self-check of the monitor circuit
// RULE7 - supply register holds sixteen supply, regulator, ground flags
// RULE8 - clock register holds frequency and two watchdog flags, enabled
// RULE9 - digital register holds three section checksums and memory check
// RULE10 - primary register holds reset and four serial fault flags
// RULE11 - indicators: command response, lock, clock, mode, sequence, bank
// RULE12 - secondary register holds three two-bit conversion counters
// RULE13 - each flag shows its fault within a bounded response time
// RULE14 - writing zero or reading never changes a latched flag
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/10ps
module mon_status (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             irq,
    // raw monitor detects, asynchronous
    input  wire logic [15:0] supply_detect,
    input  wire logic [2:0]  clock_detect,
    input  wire logic [3:0]  digital_detect,
    // serial interface events
    input  wire logic        frame_start,
    input  wire logic        frame_end,
    input  wire logic        crc_error,
    input  wire logic        timeout_error,
    input  wire logic        sclk_error,
    input  wire logic        access_error,
    // indicators and conversion events
    input  wire logic [3:0]  command_response,
    input  wire logic        lock_state,
    input  wire logic        clock_source,
    input  wire logic        operating_mode,
    input  wire logic        sequence_running_bit,
    input  wire logic        otp_bank_indicator,
    input  wire logic        conv_a_done,
    input  wire logic        conv_b_done,
    input  wire logic        sequence_done,
    // monitor and diagnostic controls
    output logic      [15:0] supply_mon_en,
    output logic      [15:0] supply_diag_en,
    output logic      [7:0]  misc_mon_en,
    output logic      [5:0]  misc_diag_en
);
    flag_if #(.N(mon_pkg::SUP_W)) sup_if ();
    flag_if #(.N(mon_pkg::CLK_W)) clk_if ();
    flag_if #(.N(mon_pkg::DIG_W)) dig_if ();
    flag_if #(.N(mon_pkg::COM_W)) com_if ();

    logic [15:0] sup_det_s;
    logic [2:0]  clk_det_s;
    logic [3:0]  dig_det_s;
    logic [1:0]  current_conv_a_counter;
    logic [1:0]  current_conv_b_counter;
    logic [1:0]  mux_sequence_counter;
    logic        clean_reg;
    logic        frame_err_reg;
    logic [3:0]  irq_stat_reg;
    logic [3:0]  irq_en_reg;
    logic [3:0]  irq_event;
    logic [15:0] rd_next;
    logic        wr_supply;
    logic        wr_clock;
    logic        wr_digital;
    logic        wr_primary;

    function automatic logic sel(input logic [7:0] a,
                                 input logic [7:0] reg_addr);
        sel = (a == reg_addr);
    endfunction

    sync2 #(.N(mon_pkg::SUP_W + mon_pkg::CLK_W + mon_pkg::DIG_W)) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       ({digital_detect, clock_detect, supply_detect}),
        .q       ({dig_det_s, clk_det_s, sup_det_s})
    );

    assign wr_supply  = wr && sel(addr, mon_pkg::A_SUPPLY);
    assign wr_clock   = wr && sel(addr, mon_pkg::A_CLOCK);
    assign wr_digital = wr && sel(addr, mon_pkg::A_DIGITAL);
    assign wr_primary = wr && sel(addr, mon_pkg::A_PRIMARY);

    // supply bank
    assign sup_if.detect  = sup_det_s;                           // RULE1
    assign sup_if.enable  = supply_mon_en;                       // RULE5
    assign sup_if.clear   = wr_supply ? wdata : 16'h0000;        // RULE3
    assign sup_if.recover = 16'h0000;                            // RULE2
    // clock bank
    assign clk_if.detect  = clk_det_s;                           // RULE13
    assign clk_if.enable  = misc_mon_en[2:0];                    // RULE8
    assign clk_if.clear   = wr_clock ? wdata[2:0] : 3'h0;
    assign clk_if.recover = 3'h0;
    // digital bank; memory check has no enable
    assign dig_if.detect  = dig_det_s;
    assign dig_if.enable  = {1'b1, misc_mon_en[7:5]};            // RULE9
    assign dig_if.clear   = wr_digital ? wdata[3:0] : 4'h0;
    assign dig_if.recover = 4'h0;

    // primary bank: reset, checksum, timeout, clock count, access
    assign com_if.detect  = {1'b0, crc_error, timeout_error,
                             sclk_error, access_error};
    assign com_if.enable  = {2'h3, misc_mon_en[mon_pkg::MISC_TIMEOUT],
                             misc_mon_en[mon_pkg::MISC_SCLK], 1'b1}; // RULE10
    assign com_if.clear   = wr_primary ? wdata[15:11] : 5'h00;
    // reset flag is cleared only by the host
    assign com_if.recover = {1'b0, {4{frame_start && clean_reg}}}; // RULE4

    flag_bank #(.N(mon_pkg::SUP_W), .RST_VAL(mon_pkg::SUP_RST)) u_sup (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fb      (sup_if.bank)
    );
    flag_bank #(.N(mon_pkg::CLK_W), .RST_VAL(mon_pkg::CLK_RST)) u_clk (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fb      (clk_if.bank)
    );
    flag_bank #(.N(mon_pkg::DIG_W), .RST_VAL(mon_pkg::DIG_RST)) u_dig (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fb      (dig_if.bank)
    );
    flag_bank #(.N(mon_pkg::COM_W), .RST_VAL(mon_pkg::COM_RST)) u_com (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fb      (com_if.bank)
    );

    // track whether the last finished frame was free of serial faults
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_err_reg <= 1'b0;
            clean_reg     <= 1'b0;
        end else begin
            if (frame_end) begin                                 // RULE4
                clean_reg     <= !(frame_err_reg || com_if.hit);
                frame_err_reg <= 1'b0;
            end else if (frame_start) begin
                frame_err_reg <= com_if.hit;
            end else if (com_if.hit) begin
                frame_err_reg <= 1'b1;
            end
        end
    end

    // monitor enables
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_mon_en <= mon_pkg::SUP_EN_RST;
            misc_mon_en   <= mon_pkg::MISC_EN_RST;
        end else if (wr && sel(addr, mon_pkg::A_SUP_EN)) begin
            supply_mon_en <= wdata;                              // RULE5
        end else if (wr && sel(addr, mon_pkg::A_MISC_EN)) begin
            misc_mon_en <= wdata[7:0];
        end
    end

    // diagnostic enables drive the monitors' self-check inputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_diag_en <= 16'h0000;
            misc_diag_en   <= 6'h00;
        end else if (wr && sel(addr, mon_pkg::A_SUP_DIAG)) begin
            supply_diag_en <= wdata & mon_pkg::SUP_DIAG_MASK;    // RULE6
        end else if (wr && sel(addr, mon_pkg::A_MISC_DIAG)) begin
            misc_diag_en <= wdata[5:0];                          // RULE6
        end
    end

    // conversion and sequence counters wrap at four
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            current_conv_a_counter <= 2'h0;
            current_conv_b_counter <= 2'h0;
            mux_sequence_counter   <= 2'h0;
        end else begin
            if (conv_a_done) begin
                current_conv_a_counter <= current_conv_a_counter + 2'h1;
            end
            if (conv_b_done) begin
                current_conv_b_counter <= current_conv_b_counter + 2'h1;
            end
            if (sequence_done) begin                             // RULE12
                mux_sequence_counter <= mux_sequence_counter + 2'h1;
            end
        end
    end

    // interrupt: supply, clock, digital, serial events; set beats clear
    assign irq_event = {com_if.hit, dig_if.hit, clk_if.hit, sup_if.hit};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= 4'h0;
        end else if (wr && sel(addr, mon_pkg::A_IRQ_CLR)) begin
            irq_stat_reg <= (irq_stat_reg & ~wdata[3:0]) | irq_event;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_event;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= 4'h0;
        end else if (wr && sel(addr, mon_pkg::A_IRQ_EN)) begin
            irq_en_reg <= wdata[3:0];
        end
    end

    // one cycle behind the status bit, so the pin is glitch free
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // read mux; reads have no side effect on any flag
    always_comb begin
        unique case (addr)
            mon_pkg::A_PRIMARY:   rd_next = {com_if.flag_n, 3'h0,
                                     command_response, 1'b0, lock_state,
                                     clock_source, operating_mode}; // RULE11
            mon_pkg::A_SECONDARY: rd_next = {8'h00, sequence_running_bit,
                                     1'b0, mux_sequence_counter,
                                     current_conv_b_counter,
                                     current_conv_a_counter};
            mon_pkg::A_SUPPLY:    rd_next = sup_if.flag_n;       // RULE7
            mon_pkg::A_CLOCK:     rd_next = {13'h0000, clk_if.flag_n};
            mon_pkg::A_DIGITAL:   rd_next = {11'h000, otp_bank_indicator,
                                     dig_if.flag_n};
            mon_pkg::A_SUP_EN:    rd_next = supply_mon_en;
            mon_pkg::A_SUP_DIAG:  rd_next = supply_diag_en;
            mon_pkg::A_MISC_EN:   rd_next = {8'h00, misc_mon_en};
            mon_pkg::A_MISC_DIAG: rd_next = {10'h000, misc_diag_en};
            mon_pkg::A_IRQ_STAT:  rd_next = {12'h000, irq_stat_reg};
            mon_pkg::A_IRQ_EN:    rd_next = {12'h000, irq_en_reg};
            default:              rd_next = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else begin                                           // RULE14
            rdata <= rd ? rd_next : 16'h0000;
        end
    end

    // checks
    property p_fault_low;
        @(posedge sys_clk) disable iff (!rst_n)
        ((sup_if.detect & sup_if.enable) != 16'h0000) |=>
            ((sup_if.flag_n & $past(sup_if.detect & sup_if.enable))
             == 16'h0000);
    endproperty
    a_fault_low: assert property (p_fault_low) // RULE1
        else $error("enabled supply fault did not pull its flag low");
    property p_recover;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_start && clean_reg && !com_if.hit |=>
            (com_if.flag_n[3:0] == 4'hf);
    endproperty
    a_recover: assert property (p_recover) // RULE4
        else $error("serial flags did not recover after clean frame");
    property p_diag_write;
        @(posedge sys_clk) disable iff (!rst_n)
        wr && sel(addr, mon_pkg::A_MISC_DIAG) |=>
            (misc_diag_en == $past(wdata[5:0]));
    endproperty
    a_diag_write: assert property (p_diag_write) // RULE6
        else $error("diagnostic enable did not take the written value");
    property p_supply_read;
        @(posedge sys_clk) disable iff (!rst_n)
        rd && sel(addr, mon_pkg::A_SUPPLY) |=>
            (rdata == $past(sup_if.flag_n));
    endproperty
    a_supply_read: assert property (p_supply_read) // RULE7
        else $error("supply read data wrong");
    property p_clock_read;
        @(posedge sys_clk) disable iff (!rst_n)
        rd && sel(addr, mon_pkg::A_CLOCK) |=>
            (rdata == {13'h0000, $past(clk_if.flag_n)});
    endproperty
    a_clock_read: assert property (p_clock_read) // RULE8
        else $error("clock read data wrong");
    property p_primary_read;
        @(posedge sys_clk) disable iff (!rst_n)
        rd && sel(addr, mon_pkg::A_PRIMARY) |=>
            (rdata[15:11] == $past(com_if.flag_n)) &&
            (rdata[7:4] == $past(command_response));
    endproperty
    a_primary_read: assert property (p_primary_read) // RULE10
        else $error("primary read data wrong");
    property p_counter;
        @(posedge sys_clk) disable iff (!rst_n)
        conv_a_done |=>
            (current_conv_a_counter == $past(current_conv_a_counter)
             + 2'h1);
    endproperty
    a_counter: assert property (p_counter) // RULE12
        else $error("conversion counter did not advance");
    property p_response;
        @(posedge sys_clk) disable iff (!rst_n)
        (clock_detect[0] && misc_mon_en[0])[*4] |-> !clk_if.flag_n[0];
    endproperty
    a_response: assert property (p_response) // RULE13
        else $error("watchdog flag slower than three cycles");
    property p_read_keeps;
        @(posedge sys_clk) disable iff (!rst_n)
        rd && !dig_if.hit |=> $stable(dig_if.flag_n);
    endproperty
    a_read_keeps: assert property (p_read_keeps) // RULE14
        else $error("reading changed a digital flag");
    c_supply_fault: cover property (@(posedge sys_clk) disable iff (!rst_n)
        sup_if.hit ##1 wr_supply);
    c_recover: cover property (@(posedge sys_clk) disable iff (!rst_n)
        frame_start && clean_reg && !com_if.flag_n[3]);
    c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(irq));
endmodule

// [tb/host_model.sv]
// host side of the register port: one-cycle write and read strobes
// assumes rdata answers exactly one cycle after the read strobe
`timescale 1ns/10ps
module host_model (
    // clock
    input  wire logic        sys_clk,
    // register port
    output logic      [7:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata
);
    initial begin
        addr  = 8'h00;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // released lines show the inverse so stale values never look valid
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        addr <= ~a;
        // data launched at the previous edge, still standing here
        @(posedge sys_clk);
        d = rdata;
    endtask
endmodule

// [tb/mon_status_bench.sv]
// self-checking bench for the monitor fault status bank
// assumes the host model drives the register port
`timescale 1ns/10ps
module mon_status_bench;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, supply_mon_en, supply_diag_en;
    logic        wr, rd, irq;
    logic [7:0]  misc_mon_en;
    logic [5:0]  misc_diag_en;
    logic [15:0] supply_detect = 16'h0000;
    logic [2:0]  clock_detect  = 3'h0;
    logic [3:0]  digital_detect = 4'h0;
    logic        frame_start = 1'b0;
    logic        frame_end   = 1'b0;
    logic [3:0]  serr = 4'h0;
    logic [2:0]  ev   = 3'h0;
    logic        seq_run = 1'b0;
    logic        otp     = 1'b0;
    int          n_errors = 0;
    int          n_checks = 0;

    always #25 sys_clk = ~sys_clk;

    host_model host (.sys_clk, .addr, .wdata, .wr, .rd, .rdata);

    mon_status dut (.sys_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
        .irq, .supply_detect, .clock_detect, .digital_detect,
        .frame_start, .frame_end, .crc_error(serr[3]),
        .timeout_error(serr[2]), .sclk_error(serr[1]),
        .access_error(serr[0]), .command_response(4'h5),
        .lock_state(1'b1), .clock_source(1'b0), .operating_mode(1'b1),
        .sequence_running_bit(seq_run), .otp_bank_indicator(otp),
        .conv_a_done(ev[0]), .conv_b_done(ev[1]),
        .sequence_done(ev[2]), .supply_mon_en, .supply_diag_en,
        .misc_mon_en, .misc_diag_en);

    task automatic final_report();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.read_reg(a, d);
        check(d, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic pulses(input int k, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ev[k] <= 1'b1;
            @(posedge sys_clk);
            ev[k] <= 1'b0;
        end
    endtask

    // one serial frame, errors raised in its middle cycle
    task automatic frame(input logic [3:0] e);
        @(posedge sys_clk);
        frame_start <= 1'b1;
        @(posedge sys_clk);
        frame_start <= 1'b0;
        serr        <= e;
        @(posedge sys_clk);
        serr      <= 4'h0;
        frame_end <= 1'b1;
        @(posedge sys_clk);
        frame_end <= 1'b0;
    endtask

    task automatic t_reset();
        rd_chk(mon_pkg::A_PRIMARY, 16'h7855);
        rd_chk(mon_pkg::A_SUPPLY, 16'hffff);
        rd_chk(mon_pkg::A_CLOCK, 16'h0007);
        rd_chk(mon_pkg::A_DIGITAL, 16'h000f);
        rd_chk(8'h20, 16'h0000);
        check(supply_mon_en, 16'hffff);
        check({8'h00, misc_mon_en}, 16'h00ff);
        host.write_reg(mon_pkg::A_PRIMARY, 16'h8000);
        rd_chk(mon_pkg::A_PRIMARY, 16'hf855);
    endtask

    task automatic t_supply();
        supply_detect <= 16'h0001;
        tick(4);
        rd_chk(mon_pkg::A_SUPPLY, 16'hfffe);
        host.write_reg(mon_pkg::A_SUPPLY, 16'h0001);
        rd_chk(mon_pkg::A_SUPPLY, 16'hfffe);
        supply_detect <= 16'h0000;
        tick(4);
        host.write_reg(mon_pkg::A_SUPPLY, 16'h0000);
        rd_chk(mon_pkg::A_SUPPLY, 16'hfffe);
        host.write_reg(mon_pkg::A_SUPPLY, 16'h0001);
        rd_chk(mon_pkg::A_SUPPLY, 16'hffff);
    endtask

    task automatic t_enable();
        host.write_reg(mon_pkg::A_SUP_EN, 16'hfffe);
        supply_detect <= 16'h8001;
        tick(4);
        rd_chk(mon_pkg::A_SUPPLY, 16'h7fff);
        supply_detect <= 16'h0000;
        tick(4);
        host.write_reg(mon_pkg::A_SUPPLY, 16'h8000);
        host.write_reg(mon_pkg::A_SUP_EN, 16'hffff);
        rd_chk(mon_pkg::A_SUPPLY, 16'hffff);
    endtask

    task automatic t_clock_digital();
        host.write_reg(mon_pkg::A_MISC_EN, 16'h001e);
        tick(1);
        check({8'h00, misc_mon_en}, 16'h001e);
        clock_detect   <= 3'h7;
        digital_detect <= 4'hf;
        otp            <= 1'b1;
        tick(4);
        rd_chk(mon_pkg::A_CLOCK, 16'h0001);
        rd_chk(mon_pkg::A_DIGITAL, 16'h0017);
        clock_detect   <= 3'h0;
        digital_detect <= 4'h0;
        host.write_reg(mon_pkg::A_MISC_EN, 16'h00ff);
        tick(4);
        host.write_reg(mon_pkg::A_CLOCK, 16'h0007);
        host.write_reg(mon_pkg::A_DIGITAL, 16'h000f);
        rd_chk(mon_pkg::A_CLOCK, 16'h0007);
        rd_chk(mon_pkg::A_DIGITAL, 16'h001f);
    endtask

    task automatic t_serial();
        frame(4'hf);
        rd_chk(mon_pkg::A_PRIMARY, 16'h8055);
        frame(4'h0);
        rd_chk(mon_pkg::A_PRIMARY, 16'h8055);
        frame(4'h0);
        rd_chk(mon_pkg::A_PRIMARY, 16'hf855);
        host.write_reg(mon_pkg::A_MISC_EN, 16'h00f7);
        frame(4'h4);
        rd_chk(mon_pkg::A_PRIMARY, 16'hf855);
        host.write_reg(mon_pkg::A_MISC_EN, 16'h00ff);
    endtask

    task automatic t_counters();
        pulses(0, 5);
        pulses(1, 2);
        pulses(2, 3);
        seq_run <= 1'b1;
        tick(2);
        rd_chk(mon_pkg::A_SECONDARY, 16'h00b9);
    endtask

    task automatic t_diag();
        host.write_reg(mon_pkg::A_SUP_DIAG, 16'hffff);
        host.write_reg(mon_pkg::A_MISC_DIAG, 16'h003f);
        tick(1);
        check(supply_diag_en, 16'he1ff);
        check({10'h000, misc_diag_en}, 16'h003f);
    endtask

    task automatic t_irq();
        int i;
        host.write_reg(mon_pkg::A_IRQ_CLR, 16'h000f);
        host.write_reg(mon_pkg::A_IRQ_EN, 16'h0002);
        clock_detect <= 3'h1;
        for (i = 0; i < 10 && irq !== 1'b1; i++)
            tick(1);
        check({15'h0000, irq}, 16'h0001);
        rd_chk(mon_pkg::A_IRQ_STAT, 16'h0002);
        clock_detect <= 3'h0;
        tick(4);
        host.write_reg(mon_pkg::A_CLOCK, 16'h0001);
        host.write_reg(mon_pkg::A_IRQ_CLR, 16'h0002);
        tick(2);
        check({15'h0000, irq}, 16'h0000);
        host.write_reg(mon_pkg::A_IRQ_EN, 16'h0000);
        supply_detect <= 16'h0002;
        tick(5);
        check({15'h0000, irq}, 16'h0000);
    endtask

    // hang guard: a run this long counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_supply();
        t_enable();
        t_clock_digital();
        t_serial();
        t_counters();
        t_diag();
        t_irq();
        final_report();
    end
endmodule
